/* File: hdl/fxpcs_defs.svh */
// constants of the 100base-x coding datapath
`ifndef FXPCS_DEFS_SVH
`define FXPCS_DEFS_SVH

`define FXPCS_CG_IDLE 5'h1f
`define FXPCS_CG_J 5'h18
`define FXPCS_CG_K 5'h11
`define FXPCS_CG_T 5'h0d
`define FXPCS_CG_R 5'h07
`define FXPCS_CG_HALT 5'h04

`define FXPCS_NIB_PREAMBLE 4'h5
`define FXPCS_NIB_INVALID 4'h6
`define FXPCS_NIB_INVALID_ALT 4'h5

`define FXPCS_SYNC_IDLES 5'h10
`define FXPCS_HOLD_IDLES 5'h10
`define FXPCS_BIT_LAST 3'h4
`define FXPCS_LOCK_SILENCE 7'h40

`define FXPCS_CLK_PERIOD_NS 8
`define FXPCS_HOLD_SHORT_NS 722000
`define FXPCS_HOLD_LONG_NS 2000000
`define FXPCS_TIMER_W 18

`endif

/* File: hdl/fxpcs_pkg.sv */
// types of the 100base-x coding datapath
package fxpcs_pkg;

  typedef enum logic [3:0] {
    FXPCS_TX_IDLE = 4'b0001,
    FXPCS_TX_K    = 4'b0010,
    FXPCS_TX_DATA = 4'b0100,
    FXPCS_TX_R    = 4'b1000
  } fxpcs_tx_state_t;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] nib;
  } fxpcs_tx_item_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] nib;
  } fxpcs_rx_nib_t;

  typedef struct packed {
    logic nrzi;
    logic descr;
    logic align;
    logic dec;
  } fxpcs_bypass_t;

  typedef struct packed {
    logic hold_long;
    logic hold_off;
    logic alt_invalid;
  } fxpcs_cfg_t;

  typedef struct packed {
    logic [4:0]  ks;
    logic [10:0] st;
  } fxpcs_ks_t;

endpackage : fxpcs_pkg

/* File: hdl/fxpcs_rx_coding.sv */
// 100base-x coding datapath: tx halt substitution, rx decode chain, tx fifo
`timescale 1ns/1ps
`default_nettype none
`include "fxpcs_defs.svh"

module fxpcs_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          ready;
    logic          empty;
  } fxpcs_fifo_state_t;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  fxpcs_fifo_state_t r_reg;
  fxpcs_fifo_state_t r_next;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  assign in_ready  = r_reg.ready;
  assign out_valid = !r_reg.empty;
  assign out_data  = mem[r_reg.rd];

  always_comb begin
    r_next = r_reg;
    push   = in_valid && r_reg.ready;
    pop    = out_ready && !r_reg.empty;
    if (push) begin
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = r_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    r_next.ready = r_next.cnt != (AW+1)'(DEPTH);
    r_next.empty = r_next.cnt == '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg       <= '0;
      r_reg.empty <= 1'b1;
      r_reg.ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[r_reg.wr] <= in_data;
    end
  end
endmodule : fxpcs_fifo

module fxpcs_rx_coding #(
  parameter int unsigned HOLD_SHORT_CYC = `FXPCS_HOLD_SHORT_NS / `FXPCS_CLK_PERIOD_NS,
  parameter int unsigned HOLD_LONG_CYC  = `FXPCS_HOLD_LONG_NS / `FXPCS_CLK_PERIOD_NS,
  parameter int          TX_DEPTH       = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire fxpcs_pkg::fxpcs_cfg_t    cfg,
  input  wire fxpcs_pkg::fxpcs_bypass_t bypass,
  input  wire fxpcs_pkg::fxpcs_tx_item_t tx_item,
  input  wire logic                     tx_valid,
  output logic                          tx_ready,
  output logic                    [4:0] tx_code,
  output logic                          tx_code_strobe,
  input  wire logic                     rx_line,
  output logic                          rx_locked,
  output logic                          descr_synced,
  output fxpcs_pkg::fxpcs_rx_nib_t      rx_out,
  output logic                          rx_strobe
);
  localparam int TW = `FXPCS_TIMER_W;
  localparam logic [4:0] CG_TAB [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  if (HOLD_SHORT_CYC == 0 || HOLD_LONG_CYC >= (1 << TW)) begin : g_chk
    $error("hold timer counts out of range");
  end

  typedef struct packed {
    logic                       s1;
    logic                       s2;
    logic                       prev;
    logic [6:0]                 sil;
    logic                       locked;
    logic [2:0]                 bitc;
    logic [3:0]                 gsr;
    logic [14:0]                hist;
    logic [10:0]                lfsr;
    logic                       synced;
    logic [4:0]                 icnt;
    logic [TW-1:0]              timer;
    logic [14:0]                win;
    logic [2:0]                 off;
    logic                       in_frame;
    logic                       t_pend;
    logic                       idle_pend;
    fxpcs_pkg::fxpcs_rx_nib_t   rx_out;
    logic                       rx_strobe;
    fxpcs_pkg::fxpcs_tx_state_t tx_st;
    logic [2:0]                 tx_slot;
    logic [4:0]                 tx_code;
    logic                       tx_strobe;
  } fxpcs_state_t;

  fxpcs_state_t              r_reg;
  fxpcs_state_t              r_next;
  fxpcs_pkg::fxpcs_tx_item_t f_item;
  logic                      f_valid;
  logic                      f_full_n;
  logic                      tx_pop;

  // 11-bit scrambler keystream, five steps per code-group
  function automatic fxpcs_pkg::fxpcs_ks_t fxpcs_ks(input logic [10:0] s);
    fxpcs_pkg::fxpcs_ks_t k;
    logic                 b;
    k.st = s;
    k.ks = '0;
    for (int i = 0; i < 5; i++) begin
      b         = k.st[10] ^ k.st[8];
      k.ks[4-i] = b;
      k.st      = {k.st[9:0], b};
    end
    return k;
  endfunction : fxpcs_ks

  fxpcs_fifo #(
    .WIDTH ($bits(fxpcs_pkg::fxpcs_tx_item_t)),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (tx_item),
    .in_valid  (tx_valid),
    .in_ready  (f_full_n),
    .out_data  (f_item),
    .out_valid (f_valid),
    .out_ready (tx_pop)
  );

  assign tx_ready       = f_full_n;
  assign tx_code        = r_reg.tx_code;
  assign tx_code_strobe = r_reg.tx_strobe;
  assign rx_locked      = r_reg.locked;
  assign descr_synced   = r_reg.synced;
  assign rx_out         = r_reg.rx_out;
  assign rx_strobe      = r_reg.rx_strobe;

  always_comb begin
    logic                 trans;
    logic                 nrz;
    logic                 bnd;
    logic [4:0]           grp;
    logic [15:0]          full;
    fxpcs_pkg::fxpcs_ks_t ks_c;
    fxpcs_pkg::fxpcs_ks_t ks_l;
    logic [4:0]           ud;
    logic                 d_ok;
    logic                 hit;
    logic [2:0]           fo;
    logic [2:0]           off_use;
    logic [4:0]           ag;
    logic                 is_data;
    logic [3:0]           dnib;
    logic [3:0]           inv_nib;
    logic [TW-1:0]        load;
    trans   = 1'b0;
    nrz     = 1'b0;
    bnd     = 1'b0;
    grp     = '0;
    full    = '0;
    ks_c    = '0;
    ks_l    = '0;
    ud      = '0;
    d_ok    = 1'b0;
    hit     = 1'b0;
    fo      = '0;
    off_use = '0;
    ag      = '0;
    is_data = 1'b0;
    dnib    = '0;
    inv_nib = '0;
    load    = '0;
    tx_pop  = 1'b0;
    r_next  = r_reg;

    // line bit is sampled on the recovered clock through two flops
    r_next.s1   = rx_line;
    r_next.s2   = r_reg.s1;
    r_next.prev = r_reg.s2;
    trans       = r_reg.s2 ^ r_reg.prev;
    nrz         = bypass.nrzi ? r_reg.s2 : trans;
    r_next.sil  = trans ? '0 : (r_reg.sil == `FXPCS_LOCK_SILENCE ? r_reg.sil
                                                                  : r_reg.sil + 7'h1);
    r_next.locked = r_next.sil != `FXPCS_LOCK_SILENCE;

    bnd           = r_reg.bitc == `FXPCS_BIT_LAST;
    r_next.bitc   = bnd ? 3'h0 : r_reg.bitc + 3'h1;
    r_next.gsr    = {r_reg.gsr[2:0], nrz};
    grp           = {r_reg.gsr, nrz};
    full          = {r_reg.hist, ~nrz};
    r_next.hist   = full[14:0];
    r_next.rx_strobe = 1'b0;

    load    = cfg.hold_long ? TW'(HOLD_LONG_CYC) : TW'(HOLD_SHORT_CYC);
    inv_nib = cfg.alt_invalid ? `FXPCS_NIB_INVALID_ALT : `FXPCS_NIB_INVALID;

    if (r_reg.synced && !cfg.hold_off) begin
      if (r_reg.timer == '0) begin
        r_next.synced = 1'b0;
        r_next.icnt   = '0;
      end else begin
        r_next.timer = r_reg.timer - 1'b1;
      end
    end

    if (bnd) begin
      ks_c = fxpcs_ks(full[15:5]);
      ks_l = fxpcs_ks(r_reg.lfsr);
      ud   = grp;
      d_ok = 1'b1;
      if (!bypass.descr) begin
        if (r_reg.synced) begin
          ud          = grp ^ ks_l.ks;
          r_next.lfsr = ks_l.st;
          if (ud == `FXPCS_CG_IDLE && r_next.synced && !cfg.hold_off) begin
            if (r_reg.icnt == `FXPCS_HOLD_IDLES - 5'h1) begin
              r_next.icnt  = '0;
              r_next.timer = load;
            end else begin
              r_next.icnt = r_reg.icnt + 5'h1;
            end
          end
        end else begin
          // candidate state is taken from the inverted line history
          d_ok = 1'b0;
          ud   = grp ^ ks_c.ks;
          if (ud != `FXPCS_CG_IDLE) begin
            r_next.icnt = '0;
          end else if (r_reg.icnt == `FXPCS_SYNC_IDLES - 5'h1) begin
            r_next.synced = 1'b1;
            r_next.icnt   = '0;
            r_next.lfsr   = ks_c.st;
            r_next.timer  = load;
          end else begin
            r_next.icnt = r_reg.icnt + 5'h1;
          end
        end
      end

      r_next.win = {r_reg.win[9:0], ud};
      if (d_ok && !r_reg.in_frame) begin
        for (int o = 0; o < 5; o++) begin
          if (!hit && (!bypass.align || o == 0) &&
              10'(r_next.win >> (5 - o)) == {`FXPCS_CG_J, `FXPCS_CG_K}) begin
            hit = 1'b1;
            fo  = 3'(o);
          end
        end
      end
      off_use = hit ? fo : r_reg.off;
      if (hit) begin
        r_next.off = fo;
      end
      ag = 5'(r_next.win >> (3'h5 - off_use));

      for (int i = 0; i < 16; i++) begin
        if (CG_TAB[i] == ag) begin
          is_data = 1'b1;
          dnib    = 4'(i);
        end
      end

      r_next.rx_strobe = 1'b1;
      r_next.rx_out    = '0;
      if (!d_ok) begin
        r_next.in_frame  = 1'b0;
        r_next.t_pend    = 1'b0;
        r_next.idle_pend = 1'b0;
      end else if (!r_reg.in_frame) begin
        if (hit) begin
          r_next.in_frame  = 1'b1;
          r_next.idle_pend = 1'b0;
          r_next.rx_out    = '{dv: 1'b1, er: 1'b0, nib: `FXPCS_NIB_PREAMBLE};
        end
      end else if (r_reg.t_pend) begin
        r_next.t_pend   = 1'b0;
        r_next.in_frame = 1'b0;
        if (ag != `FXPCS_CG_R) begin
          r_next.rx_out = '{dv: 1'b1, er: 1'b1, nib: inv_nib};
        end
      end else if (ag == `FXPCS_CG_T) begin
        r_next.t_pend = 1'b1;
      end else if (ag == `FXPCS_CG_IDLE) begin
        if (r_reg.idle_pend) begin
          r_next.in_frame  = 1'b0;
          r_next.idle_pend = 1'b0;
        end else begin
          r_next.idle_pend = 1'b1;
          r_next.rx_out    = '{dv: 1'b1, er: 1'b1, nib: inv_nib};
        end
      end else begin
        r_next.idle_pend = 1'b0;
        if (is_data) begin
          r_next.rx_out = '{dv: 1'b1, er: 1'b0, nib: dnib};
        end else begin
          r_next.rx_out = '{dv: 1'b1, er: 1'b1, nib: inv_nib};
        end
      end
      // transparent mode hands the raw aligned group out, bit 4 on er
      if (bypass.dec) begin
        r_next.rx_out = '{dv: d_ok, er: ag[4], nib: ag[3:0]};
      end
    end

    r_next.tx_strobe = 1'b0;
    if (r_reg.tx_slot == `FXPCS_BIT_LAST) begin
      r_next.tx_slot   = 3'h0;
      r_next.tx_strobe = 1'b1;
      unique case (r_reg.tx_st)
        fxpcs_pkg::FXPCS_TX_IDLE: begin
          r_next.tx_code = `FXPCS_CG_IDLE;
          tx_pop         = f_valid;
          if (f_valid && f_item.en) begin
            r_next.tx_code = `FXPCS_CG_J;
            r_next.tx_st   = fxpcs_pkg::FXPCS_TX_K;
          end
        end
        fxpcs_pkg::FXPCS_TX_K: begin
          r_next.tx_code = `FXPCS_CG_K;
          tx_pop         = f_valid && f_item.en;
          r_next.tx_st   = fxpcs_pkg::FXPCS_TX_DATA;
        end
        fxpcs_pkg::FXPCS_TX_DATA: begin
          tx_pop = f_valid;
          if (f_valid && f_item.en) begin
            r_next.tx_code = f_item.er ? `FXPCS_CG_HALT : CG_TAB[f_item.nib];
          end else begin
            r_next.tx_code = `FXPCS_CG_T;
            r_next.tx_st   = fxpcs_pkg::FXPCS_TX_R;
          end
        end
        fxpcs_pkg::FXPCS_TX_R: begin
          r_next.tx_code = `FXPCS_CG_R;
          r_next.tx_st   = fxpcs_pkg::FXPCS_TX_IDLE;
        end
      endcase
    end else begin
      r_next.tx_slot = r_reg.tx_slot + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg         <= '0;
      r_reg.tx_st   <= fxpcs_pkg::FXPCS_TX_IDLE;
      r_reg.tx_code <= `FXPCS_CG_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : fxpcs_rx_coding

`default_nettype wire

/* File: verif/fxpcs_line_src.sv */
// far-side model: nrzi line transmitter feeding the receive pin
`timescale 1ns/1ps
`default_nettype none
module fxpcs_line_src (
  input  wire logic clk,
  output logic      line
);
  logic        scr_on;
  logic        nrz_on;
  logic [10:0] lfsr_reg;

  initial begin
    line     = 1'b0;
    scr_on   = 1'b0;
    nrz_on   = 1'b0;
    lfsr_reg = 11'h2a5; // arbitrary nonzero scrambler seed
  end

  // a one toggles the line, a zero holds it; nrz_on puts the level itself on the line
  // scr_on xors each bit with the x^11+x^9+1 keystream, one step per bit
  task automatic send_bit(input logic b);
    logic k;
    @(posedge clk);
    #1;
    k        = lfsr_reg[10] ^ lfsr_reg[8];
    lfsr_reg = {lfsr_reg[9:0], k};
    if (!scr_on) begin
      k = 1'b0;
    end
    line = nrz_on ? (b ^ k) : (line ^ b ^ k);
  endtask : send_bit

  // msb goes out first in time
  task automatic send_group(input logic [4:0] grp);
    for (int i = 4; i >= 0; i--) begin
      send_bit(grp[i]);
    end
  endtask : send_group
endmodule : fxpcs_line_src
`default_nettype wire

/* File: verif/fxpcs_rx_coding_chk.sv */
// port-level checks for the coding datapath
`timescale 1ns/1ps
`default_nettype none
`include "fxpcs_defs.svh"
module fxpcs_rx_coding_chk (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire fxpcs_pkg::fxpcs_cfg_t    cfg,
  input wire fxpcs_pkg::fxpcs_bypass_t bypass,
  input wire logic                     tx_ready,
  input wire logic [4:0]               tx_code,
  input wire logic                     tx_code_strobe,
  input wire logic                     rx_line,
  input wire logic                     rx_locked,
  input wire fxpcs_pkg::fxpcs_rx_nib_t rx_out,
  input wire logic                     rx_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [7:0] quiet_reg;
  logic       line_q_reg;

  // cycles since the last line transition, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_reg  <= 8'h00;
      line_q_reg <= 1'b0;
    end else begin
      line_q_reg <= rx_line;
      if (rx_line != line_q_reg) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
    end
  end

  AST_TX_SLOT: assert property (tx_code_strobe |=> !tx_code_strobe [*4] ##1 tx_code_strobe)
    else $error("tx strobe spacing wrong");
  AST_TX_HOLD: assert property (!tx_code_strobe |-> $stable(tx_code))
    else $error("tx code changed between slots");
  AST_J_THEN_K: assert property (tx_code_strobe && tx_code == `FXPCS_CG_J |-> ##5 tx_code_strobe && tx_code == `FXPCS_CG_K)
    else $error("start pair broken");
  AST_T_THEN_R: assert property (tx_code_strobe && tx_code == `FXPCS_CG_T |-> ##5 tx_code_strobe && tx_code == `FXPCS_CG_R)
    else $error("end pair broken");
  AST_R_THEN_IDLE: assert property (tx_code_strobe && tx_code == `FXPCS_CG_R |-> ##5 tx_code == `FXPCS_CG_IDLE)
    else $error("no idle after end pair");
  AST_RX_SLOT: assert property (rx_strobe |=> !rx_strobe [*4] ##1 rx_strobe)
    else $error("rx strobe spacing wrong");
  AST_RX_HOLD: assert property (!rx_strobe |-> $stable(rx_out))
    else $error("rx output changed between groups");
  AST_RX_ERR_DV: assert property (rx_strobe && rx_out.er && !bypass.dec |-> rx_out.dv)
    else $error("receive error outside frame");
  AST_RX_INV_NIB: assert property (rx_strobe && rx_out.er && !bypass.dec |-> rx_out.nib == (cfg.alt_invalid ? `FXPCS_NIB_INVALID_ALT : `FXPCS_NIB_INVALID))
    else $error("wrong invalid nibble");
  AST_LOCK_LOST: assert property (quiet_reg > 8'h50 |-> !rx_locked)
    else $error("lock held on a silent line");

  COV_HALT: cover property (tx_code_strobe && tx_code == `FXPCS_CG_HALT);
  COV_RX_ERR: cover property (rx_strobe && rx_out.er);
  COV_FULL: cover property (!tx_ready);
endmodule : fxpcs_rx_coding_chk

bind fxpcs_rx_coding fxpcs_rx_coding_chk u_chk (
  .clk(clk), .rst(rst), .cfg(cfg), .bypass(bypass), .tx_ready(tx_ready), .tx_code(tx_code),
  .tx_code_strobe(tx_code_strobe), .rx_line(rx_line), .rx_locked(rx_locked),
  .rx_out(rx_out), .rx_strobe(rx_strobe)
);
`default_nettype wire

/* File: verif/tb_fast_ethernet_pcs_rx_coding.sv */
// self-checking bench for the coding datapath
`timescale 1ns/1ps
`default_nettype none
`include "fxpcs_defs.svh"
module tb_fast_ethernet_pcs_rx_coding;
  logic                      clk;
  logic                      rst;
  fxpcs_pkg::fxpcs_cfg_t     cfg;
  fxpcs_pkg::fxpcs_bypass_t  bypass;
  fxpcs_pkg::fxpcs_tx_item_t tx_item;
  logic                      tx_valid;
  logic                      tx_ready;
  logic [4:0]                tx_code;
  logic                      tx_code_strobe;
  logic                      rx_line;
  logic                      rx_locked;
  logic                      descr_synced;
  fxpcs_pkg::fxpcs_rx_nib_t  rx_out;
  logic                      rx_strobe;
  int                        miscompares;
  int                        n_tests;
  int                        stall_cnt;
  logic [4:0]                tx_exp[$];
  fxpcs_pkg::fxpcs_rx_nib_t  rx_exp[$];
  localparam logic [4:0] CG_TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  fxpcs_rx_coding #(.HOLD_SHORT_CYC(200), .HOLD_LONG_CYC(400), .TX_DEPTH(8)) dut (
    .clk(clk), .rst(rst), .cfg(cfg), .bypass(bypass), .tx_item(tx_item), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_code(tx_code), .tx_code_strobe(tx_code_strobe), .rx_line(rx_line),
    .rx_locked(rx_locked), .descr_synced(descr_synced), .rx_out(rx_out),
    .rx_strobe(rx_strobe));
  fxpcs_line_src src (.clk(clk), .line(rx_line));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // holds the item until the fifo takes it
  task automatic push(input logic en, input logic er, input logic [3:0] nib);
    tx_item = '{en: en, er: er, nib: nib};
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) begin
      stall_cnt++;
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : push

  task automatic tx_frame;
    logic er;
    tx_exp.push_back(`FXPCS_CG_J);
    tx_exp.push_back(`FXPCS_CG_K);
    push(1'b1, 1'b0, 4'h5);
    push(1'b1, 1'b0, 4'h5);
    for (int i = 0; i < 16; i++) begin
      er = (i == 5) || ($urandom % 4 == 0);
      tx_exp.push_back(er ? `FXPCS_CG_HALT : CG_TAB[i]);
      push(1'b1, er, i[3:0]);
    end
    tx_exp.push_back(`FXPCS_CG_T);
    tx_exp.push_back(`FXPCS_CG_R);
    push(1'b0, 1'b0, 4'h0);
    tx_valid = 1'b0;
    for (int k = 0; k < 300 && tx_exp.size() != 0; k++) @(posedge clk);
    repeat (10) @(posedge clk);
    #1;
    check("tx_refused", {5'h00, stall_cnt != 0}, 6'h01);
    check("tx_ready", {5'h00, tx_ready}, 6'h01);
  endtask : tx_frame

  task automatic rx_frame(input logic alt, input logic idle_end);
    logic [3:0] nib;
    logic [3:0] inv;
    inv = alt ? `FXPCS_NIB_INVALID_ALT : `FXPCS_NIB_INVALID;
    cfg.alt_invalid = alt;
    repeat ($urandom % 5) src.send_bit(1'b1);
    repeat (20) src.send_group(`FXPCS_CG_IDLE);
    check("rx_locked", {5'h00, rx_locked}, 6'h01);
    check("descr_synced", {5'h00, descr_synced}, {5'h00, !bypass.descr});
    rx_exp.push_back('{dv: 1'b1, er: 1'b0, nib: `FXPCS_NIB_PREAMBLE});
    src.send_group(`FXPCS_CG_J);
    src.send_group(`FXPCS_CG_K);
    for (int i = 0; i < 8; i++) begin
      nib = 4'($urandom);
      rx_exp.push_back('{dv: 1'b1, er: 1'b0, nib: nib});
      src.send_group(CG_TAB[nib]);
    end
    rx_exp.push_back('{dv: 1'b1, er: 1'b1, nib: inv});
    src.send_group(5'h19);
    if (idle_end) begin
      rx_exp.push_back('{dv: 1'b1, er: 1'b1, nib: inv});
      src.send_group(`FXPCS_CG_IDLE);
      src.send_group(`FXPCS_CG_IDLE);
    end else begin
      src.send_group(`FXPCS_CG_T);
      src.send_group(`FXPCS_CG_R);
    end
    repeat (6) src.send_group(`FXPCS_CG_IDLE);
    check("rx_dv_after", {5'h00, rx_out.dv}, 6'h00);
    check("rx_left", {5'h00, rx_exp.size() != 0}, 6'h00);
  endtask : rx_frame

  // scrambled idles give sync, then data only; exp says whether sync survives
  task automatic hold_run(input logic lng, input logic off, input logic exp);
    cfg.hold_long = lng;
    cfg.hold_off  = off;
    repeat (28) src.send_group(`FXPCS_CG_IDLE);
    check("synced_idle", {5'h00, descr_synced}, 6'h01);
    repeat (50) src.send_group(CG_TAB[0]);
    check("synced_hold", {5'h00, descr_synced}, {5'h00, exp});
  endtask : hold_run

  always @(negedge clk) begin
    if (!rst && tx_code_strobe === 1'b1 && tx_code !== `FXPCS_CG_IDLE) begin
      if (tx_exp.size() == 0) check("tx_code", {1'b0, tx_code}, 6'h3f);
      else check("tx_code", {1'b0, tx_code}, {1'b0, tx_exp.pop_front()});
    end
    if (!rst && rx_strobe === 1'b1 && (rx_out.dv !== 1'b0 || rx_out.er !== 1'b0)) begin
      if (rx_exp.size() == 0) check("rx_out", rx_out, 6'h3f);
      else check("rx_out", rx_out, rx_exp.pop_front());
    end
  end

  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    cfg = '0;
    bypass = '{nrzi: 1'b0, descr: 1'b1, align: 1'b0, dec: 1'b0};
    tx_item = '0;
    tx_valid = 1'b0;
    miscompares = 0;
    n_tests = 0;
    stall_cnt = 0;
    void'($urandom(6011));
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (100) @(posedge clk);
    #1;
    check("rx_locked", {5'h00, rx_locked}, 6'h00);
    check("descr_synced", {5'h00, descr_synced}, 6'h00);
    tx_frame();
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b1);
    bypass.descr = 1'b0;
    src.scr_on   = 1'b1;
    repeat (8) src.send_group(`FXPCS_CG_IDLE);
    rx_frame(1'b0, 1'b1);
    hold_run(1'b0, 1'b0, 1'b0);
    hold_run(1'b1, 1'b0, 1'b1);
    hold_run(1'b0, 1'b1, 1'b1);
    cfg          = '0;
    bypass.nrzi  = 1'b1;
    src.nrz_on   = 1'b1;
    repeat (8) src.send_group(`FXPCS_CG_IDLE);
    rx_frame(1'b1, 1'b0);
    tx_frame();
    end_sim();
  end
endmodule : tb_fast_ethernet_pcs_rx_coding
`default_nettype wire
